// [fieldbus_pkg.sv]
// Shared constants, types and register map of the fieldbus switch decoder
`default_nettype none
package fieldbus_pkg;
    // ============================================================
    // Timing
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned FLASH_HALF_MS  = 500;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

    // ============================================================
    // Switch layout: index 7 is position 1, index 0 is position 8
    localparam int unsigned SW_W        = 8;
    localparam int unsigned ADDR_W      = 6;
    localparam int unsigned RATE_W      = 2;
    localparam int unsigned SW_ADDR_LSB = 0;
    localparam int unsigned SW_RATE_LSB = 6;
    localparam logic [SW_W-1:0] SW_ALL_ON = 8'hFF;

    // Bit rate codes
    localparam logic [RATE_W-1:0] RATE_125K    = 2'h0;
    localparam logic [RATE_W-1:0] RATE_250K    = 2'h1;
    localparam logic [RATE_W-1:0] RATE_500K    = 2'h2;
    localparam logic [RATE_W-1:0] RATE_RESERVD = 2'h3;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFF_SWITCH   = 8'h00;
    localparam logic [7:0] OFF_DL_CFG   = 8'h04;
    localparam logic [7:0] OFF_EFF_CFG  = 8'h08;
    localparam logic [7:0] OFF_MOD_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // Field positions
    localparam int unsigned DL_ADDR_LSB  = 0;
    localparam int unsigned DL_RATE_LSB  = 8;
    localparam int unsigned EFF_ADDR_LSB = 0;
    localparam int unsigned EFF_RATE_LSB = 8;
    localparam int unsigned EFF_SRC_BIT  = 16;
    localparam int unsigned EFF_OK_BIT   = 17;
    localparam int unsigned EFF_DL_BIT   = 18;
    localparam int unsigned MS_RECOV_BIT = 0;
    localparam int unsigned MS_CRIT_BIT  = 1;
    localparam int unsigned MS_ONL_BIT   = 2;
    localparam int unsigned MS_CONN_BIT  = 3;
    localparam int unsigned MS_W         = 4;

    // Interrupt bits
    localparam int unsigned IRQ_W       = 3;
    localparam int unsigned IRQ_CFG     = 0;
    localparam int unsigned IRQ_INVALID = 1;
    localparam int unsigned IRQ_CRIT    = 2;

    // Reset values
    localparam logic [31:0]      RST_WORD = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ  = 3'h0;
    localparam logic [MS_W-1:0]  RST_MS   = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ============================================================
    // Types
    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic [ADDR_W-1:0] addr;
    } node_cfg_t;

    localparam node_cfg_t RST_CFG = 8'h00;

    // Indicator modes, Gray along off -> green -> red
    typedef enum logic [2:0] {
        LED_OFF       = 3'h0,
        LED_GRN_FLASH = 3'h1,
        LED_GRN       = 3'h3,
        LED_RED_FLASH = 3'h2,
        LED_RED       = 3'h6
    } led_mode_t;
endpackage
`default_nettype wire

// [switch_decode.sv]
// Decoder from raw configuration switches to node address and bit rate
`timescale 1ns/1ps
`default_nettype none
module switch_decode (
    input  wire logic [fieldbus_pkg::SW_W-1:0] sw,
    output fieldbus_pkg::node_cfg_t            cfg,
    output logic                               all_on,
    output logic                               rate_ok
);
    // ============================================================
    // Field extraction; a one on the bus is an ON switch
    assign cfg.addr = sw[fieldbus_pkg::SW_ADDR_LSB +: fieldbus_pkg::ADDR_W];
    assign cfg.rate = sw[fieldbus_pkg::SW_RATE_LSB +: fieldbus_pkg::RATE_W];
    assign all_on   = (sw == fieldbus_pkg::SW_ALL_ON);
    assign rate_ok  = (cfg.rate != fieldbus_pkg::RATE_RESERVD);
endmodule
`default_nettype wire

// [flash_div.sv]
// Divider giving the indicator flash phase
`timescale 1ns/1ps
`default_nettype none
module flash_div #(
    parameter int unsigned HALF_CYC = fieldbus_pkg::FLASH_HALF_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      phase
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic          phase_q;

    // ============================================================
    // Free count; phase flips every half period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q   <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign phase = phase_q;
endmodule
`default_nettype wire

// [fieldbus_switch_status_decoder.sv]
// Node address, bit rate and indicator logic of the fieldbus option module
//
// Function
// RULE_01 - Address is binary, switch positions 3 to 8
// RULE_02 - Switch ON reads as one
// RULE_03 - Positions 1-2 pick 125k, 250k, 500k, reserved
// RULE_04 - All switches ON: use downloaded address, rate
// RULE_05 - Operator sets rate switches before configuration
// RULE_06 - Address indicator lit only for invalid setting
// RULE_07 - Red flash recoverable, red steady critical
// RULE_08 - Green flash unconnected, green steady connected
// RULE_09 - Latch switches at reset exit; reserved rate invalid
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_switch_status_decoder #(
    parameter int unsigned FLASH_HALF_CYC = fieldbus_pkg::FLASH_HALF_CYC
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Configuration switches, bit 7 = position 1
    input  wire logic [fieldbus_pkg::SW_W-1:0] sw_on,
    // AXI4-Lite slave
    input  wire logic [7:0]                    s_awaddr,
    input  wire logic                          s_awvalid,
    output logic                               s_awready,
    input  wire logic [31:0]                   s_wdata,
    input  wire logic [3:0]                    s_wstrb,
    input  wire logic                          s_wvalid,
    output logic                               s_wready,
    output logic [1:0]                         s_bresp,
    output logic                               s_bvalid,
    input  wire logic                          s_bready,
    input  wire logic [7:0]                    s_araddr,
    input  wire logic                          s_arvalid,
    output logic                               s_arready,
    output logic [31:0]                        s_rdata,
    output logic [1:0]                         s_rresp,
    output logic                               s_rvalid,
    input  wire logic                          s_rready,
    // Applied configuration towards the network controller
    output logic [fieldbus_pkg::ADDR_W-1:0]    node_addr,
    output logic [fieldbus_pkg::RATE_W-1:0]    bit_rate,
    output logic                               cfg_valid,
    // Indicators and interrupt
    output logic                               addr_led_red,
    output logic                               stat_led_red,
    output logic                               stat_led_green,
    output logic                               irq
);
    // ============================================================
    // State
    logic [fieldbus_pkg::SW_W-1:0]   sw_q;
    logic                            latched_q;
    fieldbus_pkg::node_cfg_t         dl_cfg_q;
    logic                            dl_loaded_q;
    logic [fieldbus_pkg::MS_W-1:0]   ms_q;
    logic [fieldbus_pkg::IRQ_W-1:0]  irq_stat_q;
    logic [fieldbus_pkg::IRQ_W-1:0]  irq_stat_d;
    logic [fieldbus_pkg::IRQ_W-1:0]  irq_mask_q;
    logic                            invalid_q;
    logic                            crit_q;
    fieldbus_pkg::led_mode_t         mode_q;
    fieldbus_pkg::led_mode_t         mode_d;
    fieldbus_pkg::node_cfg_t         out_cfg_q;
    logic                            out_ok_q;
    logic                            addr_led_q;
    logic                            red_q;
    logic                            green_q;
    logic                            irq_q;

    // Bus state
    logic                            awready_q;
    logic                            wready_q;
    logic                            aw_full_q;
    logic                            w_full_q;
    logic [7:0]                      aw_addr_q;
    logic [31:0]                     w_data_q;
    logic [3:0]                      w_strb_q;
    logic                            bvalid_q;
    logic [1:0]                      bresp_q;
    logic                            arready_q;
    logic                            rvalid_q;
    logic [31:0]                     rdata_q;
    logic [1:0]                      rresp_q;

    // ============================================================
    // Switch decoding of the latched copy
    fieldbus_pkg::node_cfg_t sw_cfg;
    logic                    sw_all_on;
    logic                    sw_rate_ok;

    switch_decode u_dec (
        .sw      (sw_q),
        .cfg     (sw_cfg),      // [RULE_01] [RULE_02] [RULE_03]
        .all_on  (sw_all_on),
        .rate_ok (sw_rate_ok)
    );

    logic flash_ph;

    flash_div #(
        .HALF_CYC (FLASH_HALF_CYC)
    ) u_flash (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (flash_ph)
    );

    // ============================================================
    // Effective configuration
    wire                          use_dl   = sw_all_on;         // [RULE_04]
    wire fieldbus_pkg::node_cfg_t eff_cfg  = use_dl ? dl_cfg_q : sw_cfg;
    wire eff_rate_ok = (eff_cfg.rate != fieldbus_pkg::RATE_RESERVD);
    // Download mode is only valid once software has written a setting
    wire eff_ok = latched_q && eff_rate_ok
                  && (!use_dl || dl_loaded_q);                  // [RULE_09]

    // ============================================================
    // Write path decode
    wire aw_take  = s_awvalid && awready_q;
    wire w_take   = s_wvalid && wready_q;
    wire do_write = aw_full_q && w_full_q && !bvalid_q;
    wire wr_dl    = do_write && (aw_addr_q == fieldbus_pkg::OFF_DL_CFG);
    wire wr_ms    = do_write && (aw_addr_q == fieldbus_pkg::OFF_MOD_STAT);
    wire wr_ist   = do_write && (aw_addr_q == fieldbus_pkg::OFF_IRQ_STAT);
    wire wr_imk   = do_write && (aw_addr_q == fieldbus_pkg::OFF_IRQ_MASK);
    wire wr_ro    = (aw_addr_q == fieldbus_pkg::OFF_SWITCH)
                    || (aw_addr_q == fieldbus_pkg::OFF_EFF_CFG);
    wire wr_hit   = wr_dl || wr_ms || wr_ist || wr_imk
                    || (do_write && wr_ro);

    // Byte lane mask from the strobes
    logic [31:0] lane_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{w_strb_q[gi]}};
        end
    endgenerate
    wire [31:0] wdat = w_data_q & lane_mask;

    // Fields of the written word, masked lanes read as untouched
    wire [31:0] dl_word = {16'h0000, 6'h00, dl_cfg_q.rate, 2'h0,
                           dl_cfg_q.addr};
    wire [31:0] dl_new  = wdat | (dl_word & ~lane_mask);
    wire [3:0]  ms_new  = wdat[3:0] | (ms_q & ~lane_mask[3:0]);
    wire [2:0]  imk_new = wdat[2:0] | (irq_mask_q & ~lane_mask[2:0]);
    wire [2:0]  ist_clr = wr_ist ? wdat[2:0] : 3'h0;

    // ============================================================
    // Read data selection
    wire [31:0] eff_word = {13'h0000, dl_loaded_q, eff_ok, use_dl,
                            6'h00, eff_cfg.rate, 2'h0, eff_cfg.addr};
    wire [7:0]  ra = s_araddr;
    wire rd_sw  = (ra == fieldbus_pkg::OFF_SWITCH);
    wire rd_dl  = (ra == fieldbus_pkg::OFF_DL_CFG);
    wire rd_eff = (ra == fieldbus_pkg::OFF_EFF_CFG);
    wire rd_ms  = (ra == fieldbus_pkg::OFF_MOD_STAT);
    wire rd_ist = (ra == fieldbus_pkg::OFF_IRQ_STAT);
    wire rd_imk = (ra == fieldbus_pkg::OFF_IRQ_MASK);
    wire rd_hit = rd_sw || rd_dl || rd_eff || rd_ms || rd_ist || rd_imk;
    wire [31:0] rd_word =
        rd_sw  ? {24'h000000, sw_q} :
        rd_dl  ? dl_word :
        rd_eff ? eff_word :
        rd_ms  ? {28'h0000000, ms_q} :
        rd_ist ? {29'h00000000, irq_stat_q} :
        rd_imk ? {29'h00000000, irq_mask_q} :
                 fieldbus_pkg::RST_WORD;
    wire ar_take = s_arvalid && arready_q;

    // ============================================================
    // Write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_awaddr;
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (w_take) begin
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
            end
            // Reopen only after the response leaves
            if (bvalid_q && s_bready) begin
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= fieldbus_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? fieldbus_pkg::RESP_OKAY
                               : fieldbus_pkg::RESP_SLVERR;
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel, one read outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= fieldbus_pkg::RST_WORD;
            rresp_q   <= fieldbus_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit ? fieldbus_pkg::RESP_OKAY
                                : fieldbus_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ============================================================
    // Switch capture once after reset; later moves are ignored,
    // so the rate must be set before reset is released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_q      <= 8'h00;
            latched_q <= 1'b0;
        end else if (!latched_q) begin
            sw_q      <= sw_on;                           // [RULE_09] [RULE_05]
            latched_q <= 1'b1;
        end
    end

    // Downloaded configuration and module state from software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dl_cfg_q    <= fieldbus_pkg::RST_CFG;
            dl_loaded_q <= 1'b0;
            ms_q        <= fieldbus_pkg::RST_MS;
            irq_mask_q  <= fieldbus_pkg::RST_IRQ;
        end else begin
            if (wr_dl) begin
                dl_cfg_q.addr <= dl_new[fieldbus_pkg::DL_ADDR_LSB +: 6]; // [RULE_04]
                dl_cfg_q.rate <= dl_new[fieldbus_pkg::DL_RATE_LSB +: 2];
                dl_loaded_q   <= 1'b1;
            end
            if (wr_ms) begin
                ms_q <= ms_new;
            end
            if (wr_imk) begin
                irq_mask_q <= imk_new;
            end
        end
    end

    // ============================================================
    // Sticky events; a set in the clearing cycle survives
    wire ev_cfg   = (latched_q && !out_ok_q && eff_ok) || wr_dl;
    wire ev_inval = latched_q && !eff_ok && !invalid_q;
    wire ev_crit  = ms_q[fieldbus_pkg::MS_CRIT_BIT] && !crit_q;
    wire [2:0] ev = {ev_crit, ev_inval, ev_cfg};
    assign irq_stat_d = (irq_stat_q & ~ist_clr) | ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= fieldbus_pkg::RST_IRQ;
            invalid_q  <= 1'b0;
            crit_q     <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            invalid_q  <= latched_q && !eff_ok;
            crit_q     <= ms_q[fieldbus_pkg::MS_CRIT_BIT];
            irq_q      <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ============================================================
    // Status indicator mode; faults outrank link state
    always_comb begin
        case (1'b1)
            ms_q[fieldbus_pkg::MS_CRIT_BIT]:
                mode_d = fieldbus_pkg::LED_RED;            // [RULE_07]
            ms_q[fieldbus_pkg::MS_RECOV_BIT]:
                mode_d = fieldbus_pkg::LED_RED_FLASH;      // [RULE_07]
            ms_q[fieldbus_pkg::MS_ONL_BIT] && ms_q[fieldbus_pkg::MS_CONN_BIT]:
                mode_d = fieldbus_pkg::LED_GRN;            // [RULE_08]
            ms_q[fieldbus_pkg::MS_ONL_BIT]:
                mode_d = fieldbus_pkg::LED_GRN_FLASH;      // [RULE_08]
            default:
                mode_d = fieldbus_pkg::LED_OFF;
        endcase
    end

    // Indicator drive from the registered mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= fieldbus_pkg::LED_OFF;
            red_q   <= 1'b0;
            green_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            case (mode_q)
                fieldbus_pkg::LED_RED: begin
                    red_q   <= 1'b1;
                    green_q <= 1'b0;
                end
                fieldbus_pkg::LED_RED_FLASH: begin
                    red_q   <= flash_ph;
                    green_q <= 1'b0;
                end
                fieldbus_pkg::LED_GRN: begin
                    red_q   <= 1'b0;
                    green_q <= 1'b1;
                end
                fieldbus_pkg::LED_GRN_FLASH: begin
                    red_q   <= 1'b0;
                    green_q <= flash_ph;
                end
                default: begin
                    red_q   <= 1'b0;
                    green_q <= 1'b0;
                end
            endcase
        end
    end

    // Applied configuration and address indicator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_cfg_q  <= fieldbus_pkg::RST_CFG;
            out_ok_q   <= 1'b0;
            addr_led_q <= 1'b0;
        end else begin
            out_cfg_q  <= eff_cfg;
            out_ok_q   <= eff_ok;
            addr_led_q <= latched_q && !eff_ok;           // [RULE_06]
        end
    end

    // ============================================================
    // Outputs
    assign s_awready      = awready_q;
    assign s_wready       = wready_q;
    assign s_bvalid       = bvalid_q;
    assign s_bresp        = bresp_q;
    assign s_arready      = arready_q;
    assign s_rvalid       = rvalid_q;
    assign s_rdata        = rdata_q;
    assign s_rresp        = rresp_q;
    assign node_addr      = out_cfg_q.addr;
    assign bit_rate       = out_cfg_q.rate;
    assign cfg_valid      = out_ok_q;
    assign addr_led_red   = addr_led_q;
    assign stat_led_red   = red_q;
    assign stat_led_green = green_q;
    assign irq            = irq_q;
endmodule
`default_nettype wire

// [dip_switch_bank.sv]
// Operator switch bank model standing in front of the decoder
`timescale 1ns/1ps
`default_nettype none
module dip_switch_bank (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] setting,
    output logic      [7:0] sw_on
);
    // ============================================================
    // Switch positions, ON drives a one
    initial sw_on = 8'h00;
    // Operator moves switches only while held in reset, never mid-run
    always @(posedge aclk) begin
        if (!aresetn) begin
            sw_on <= setting;
        end
    end
endmodule
`default_nettype wire

// [fsd_properties.sv]
// Port checks of the fieldbus switch status decoder
`timescale 1ns/1ps
`default_nettype none
module fsd_properties (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [7:0] sw_on,
    input wire logic       s_awvalid,
    input wire logic       s_awready,
    input wire logic       s_wvalid,
    input wire logic       s_wready,
    input wire logic       s_bvalid,
    input wire logic       s_bready,
    input wire logic       s_arvalid,
    input wire logic       s_arready,
    input wire logic       s_rvalid,
    input wire logic       s_rready,
    input wire logic [5:0] node_addr,
    input wire logic [1:0] bit_rate,
    input wire logic       cfg_valid,
    input wire logic       addr_led_red,
    input wire logic       stat_led_red,
    input wire logic       stat_led_green
);
    // ============================================================
    // Own copy of the switches taken at the first edge out of reset
    logic [7:0] cap_q;
    logic [1:0] cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 2'h0;
        end else if (cnt_q != 2'h2) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'h0) cap_q <= sw_on;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Switch mode only: download mode is judged by the bench
    sequence seq_sw_mode; cnt_q == 2'h2 && cap_q != 8'hFF; endsequence
    sequence seq_wr_take; s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence seq_wr_answer; !s_awready && !s_bvalid ##1 s_bvalid; endsequence
    AST_ADDR: assert property (seq_sw_mode |-> node_addr == cap_q[5:0])
        else $error("node address differs from switches");
    AST_RATE: assert property (seq_sw_mode |-> bit_rate == cap_q[7:6])
        else $error("bit rate differs from switches");
    AST_ALED: assert property (seq_sw_mode |->
        addr_led_red == (cap_q[7:6] == 2'h3))
        else $error("address indicator wrong");
    AST_VALID: assert property (seq_sw_mode |-> cfg_valid != addr_led_red)
        else $error("valid flag and indicator disagree");
    AST_STAT_EXCL: assert property (!(stat_led_red && stat_led_green))
        else $error("status indicator red and green together");
    AST_WR_RESP: assert property (seq_wr_take |=> seq_wr_answer)
        else $error("write response timing wrong");
    AST_RD_RESP: assert property (s_arvalid && s_arready |=>
        s_rvalid && !s_arready) else $error("read response timing wrong");
    AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_rvalid && !s_rready |=> $stable(s_rvalid))
        else $error("read data dropped early");
endmodule
bind fieldbus_switch_status_decoder fsd_properties i_props (.*);
`default_nettype wire

// [fieldbus_switch_status_decoder_tb.sv]
// Self-checking bench of the fieldbus switch status decoder
`timescale 1ns/1ps
`default_nettype none
module fieldbus_switch_status_decoder_tb;
    localparam int HALF = 4;
    localparam int N = 4 * HALF;
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready;
    logic        s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
    logic        s_arready, s_rvalid, cfg_valid, addr_led_red, irq;
    logic        stat_led_red, stat_led_green;
    logic [7:0]  s_awaddr, s_araddr, sw_set, sw_on;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, bit_rate, rsp;
    logic [5:0]  node_addr;
    logic [7:0]  tab [4] = '{8'h01, 8'h7E, 8'hBD, 8'hC5};
    int          num_errors = 0;
    int          n_tests = 0;
    fieldbus_switch_status_decoder #(.FLASH_HALF_CYC(HALF)) i_dut (.*);
    dip_switch_bank i_sw (.aclk(aclk), .aresetn(aresetn), .setting(sw_set),
                          .sw_on(sw_on));
    // ============================================================
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (4000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_awready) begin aw = 1'b0; s_awvalid <= 1'b0; end
            if (w && s_wready) begin w = 1'b0; s_wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (!s_bvalid);
        rsp = s_bresp;
        s_bready <= 1'b0;
        repeat (3) @(posedge aclk); // Indicator and irq lag after commit
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        rd = s_rdata;
        rsp = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic rst(input logic [7:0] s);
        @(posedge aclk);
        aresetn <= 1'b0;
        sw_set <= s;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    // Counts lit cycles over two flash periods: steady N, flashing N/2
    task automatic led(input logic [3:0] v, input int er, input int eg);
        logic [31:0] r, g;
        wr(fieldbus_pkg::OFF_MOD_STAT, {28'h0, v});
        r = 0;
        g = 0;
        repeat (N) begin
            @(posedge aclk);
            r += stat_led_red;
            g += stat_led_green;
        end
        chk("status red", er, r);
        chk("status green", eg, g);
    endtask
    // ============================================================
    // Test sequence
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {sw_set, s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hF;
        for (int i = 0; i < 4; i++) begin
            rst(tab[i]);
            chk("address", tab[i][5:0], node_addr);
            chk("rate", tab[i][7:6], bit_rate);
            chk("addr led", tab[i][7:6] == 2'h3, addr_led_red);
            rd_reg(fieldbus_pkg::OFF_SWITCH);
            chk("switch reg", tab[i], rd);
        end
        rst(8'hFF);
        chk("download led", 1'b1, addr_led_red);
        wr(fieldbus_pkg::OFF_IRQ_MASK, 32'h0);
        wr(fieldbus_pkg::OFF_DL_CFG, 32'h0000_0115);
        chk("dl resp", fieldbus_pkg::RESP_OKAY, rsp);
        chk("dl valid", 1'b1, cfg_valid);
        chk("dl address", 6'h15, node_addr);
        chk("dl rate", 2'h1, bit_rate);
        chk("dl led", 1'b0, addr_led_red);
        chk("irq masked", 1'b0, irq);
        wr(fieldbus_pkg::OFF_IRQ_MASK, 32'h1);
        chk("irq raised", 1'b1, irq);
        wr(fieldbus_pkg::OFF_IRQ_STAT, 32'h1);
        chk("irq cleared", 1'b0, irq);
        rd_reg(8'h18);
        chk("unmapped resp", fieldbus_pkg::RESP_SLVERR, rsp);
        chk("unmapped data", 32'h0, rd);
        wr(8'h05, 32'hFFFF_FFFF);
        chk("unaligned resp", fieldbus_pkg::RESP_SLVERR, rsp);
        led(4'h2, N, 0);
        led(4'h1, N / 2, 0);
        led(4'h3, N, 0);
        led(4'h4, 0, N / 2);
        led(4'hC, 0, N);
        led(4'h0, 0, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
